//--- design/mcsr_consts.svh
/*
 * Constants of the shift and rotate unit: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included by bare name from design files only.
 */
`ifndef MCSR_CONSTS_SVH
`define MCSR_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MCSR_OFF_OPA 8'h00
`define MCSR_OFF_OPB 8'h04
`define MCSR_OFF_CTRL 8'h08
`define MCSR_OFF_RESULT 8'h0c
`define MCSR_OFF_STATUS 8'h10
`define MCSR_OFF_MLC 8'h14

// ****************************************************************
// Control fields
// ****************************************************************
`define MCSR_CTRL_OP_HI 2
`define MCSR_CTRL_OP_LO 0
`define MCSR_CTRL_XFER 4
`define MCSR_CTRL_COND 5
`define MCSR_CTRL_IMM 6
`define MCSR_CTRL_PAGE_HI 13
`define MCSR_CTRL_PAGE_LO 8
`define MCSR_CTRL_DATA_HI 31
`define MCSR_CTRL_DATA_LO 20

// ****************************************************************
// Status fields and reset values
// ****************************************************************
`define MCSR_ST_BUSY 0
`define MCSR_ST_C 1
`define MCSR_ST_V 2
`define MCSR_ST_G 3
`define MCSR_ST_L 4
`define MCSR_RST_WORD 32'h0000_0000
`define MCSR_RST_MLC 16'h0000

// ****************************************************************
// Timing in ns
// ****************************************************************
`define MCSR_CLK_NS 100
`define MCSR_BASE_NS 360
`define MCSR_NOXFER_NS 500
`define MCSR_STEP_NS 60

`endif

//--- design/mcsr_pkg.sv
/*
 * Types of the shift and rotate unit: operations and control states.
 * Assumes nothing of its surroundings.
 */
package mcsr_pkg;

	// Operation codes held in the control register
	typedef enum logic [2:0] {
		shift_right_logical = 3'h0,
		halfword_right_logical = 3'h1,
		shift_left_arith = 3'h2,
		halfword_left_arith = 3'h3,
		shift_right_arith = 3'h4,
		halfword_right_arith = 3'h5,
		rotate_left = 3'h6,
		rotate_right = 3'h7
	} mcsr_op_t;

	// Control states, Gray coded around the loop
	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_load = 2'h1,
		st_run = 2'h3,
		st_commit = 2'h2
	} mcsr_state_t;

endpackage

//--- design/mcsr_barrel.sv
/*
 * Combinational barrel for all shift and rotate operations.
 * Assumes operand and count stay stable while the result is used.
 */
`timescale 1ns/1ps
`default_nettype none
module mcsr_barrel
	import mcsr_pkg::*;
(
	input wire mcsr_op_t op,
	input wire logic [31:0] operand,
	input wire logic [4:0] cnt,
	output logic [31:0] result,
	output logic carry
);

	// ****************************************************************
	// Shifted fields
	// ****************************************************************
	// An extra bit below or above each shift field catches the last bit out;
	// a zero count leaves it clear
	wire [3:0] hc = cnt[3:0];
	wire [32:0] srl_w = {operand, 1'b0} >> cnt;
	wire [31:0] sla_w = {1'b0, operand[30:0]} << cnt;
	wire [32:0] sra_w = $signed({operand, 1'b0}) >>> cnt;
	wire [16:0] halfword_right_logical_w = {operand[15:0], 1'b0} >> hc;
	wire [15:0] halfword_left_arith_w = {1'b0, operand[14:0]} << hc;
	wire [16:0] halfword_right_arith_w = $signed({operand[15:0], 1'b0}) >>> hc;
	wire [63:0] rol_w = {operand, operand} << cnt;
	wire [63:0] ror_w = {operand, operand} >> cnt;

	// Select by operation; carry follows the last bit out of a shift, rotates leave it clear
	always_comb begin
		result = operand;
		carry = 1'b0;
		case (op)
		shift_right_logical: begin
			result = srl_w[32:1];
			carry = srl_w[0];
		end
		halfword_right_logical: begin
			result = {operand[31:16], halfword_right_logical_w[16:1]};
			carry = halfword_right_logical_w[0];
		end
		shift_left_arith: begin
			result = {operand[31], sla_w[30:0]};
			carry = sla_w[31];
		end
		halfword_left_arith: begin
			result = {operand[31:15], halfword_left_arith_w[14:0]};
			carry = halfword_left_arith_w[15];
		end
		shift_right_arith: begin
			result = {operand[31], sra_w[31:1]};
			carry = sra_w[0];
		end
		halfword_right_arith: begin
			result = {operand[31:15], halfword_right_arith_w[15:1]};
			carry = halfword_right_arith_w[0];
		end
		rotate_left: begin
			result = rol_w[63:32];
		end
		rotate_right: begin
			result = ror_w[31:0];
		end
		default: begin
			result = operand;
		end
		endcase
	end

endmodule
`default_nettype wire

//--- design/mcsr_timer.sv
/*
 * Down counter that paces one operation.
 * Assumes start is a one-cycle pulse while the counter is at zero.
 */
`timescale 1ns/1ps
`default_nettype none
module mcsr_timer #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire logic [W-1:0] cycles,
	output logic busy,
	output logic done
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// Load on start, count down to zero otherwise
	assign cnt_next = start ? cycles :
		(cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
	assign busy = (cnt_reg != '0);
	assign done = (cnt_reg == {{(W-1){1'b0}}, 1'b1});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

endmodule
`default_nettype wire

//--- design/mcsr_unit.sv
/*
 * Shift and rotate unit with an APB register slave. Software loads
 * the operands, writes the control word to start, and reads back the
 * result, the flags and the micro-location counter.
 * Assumes an APB master on pclk and a clock of 100 ns.
 */
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.svh"
module mcsr_unit
	import mcsr_pkg::*;
#(
	parameter int AW = 8,
	parameter int TW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy
);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************

	// Halfword forms use a four-bit count and a 16-bit flag field
	function automatic logic is_half(input mcsr_op_t o);
		is_half = (o == halfword_right_logical) ||
			(o == halfword_left_arith) ||
			(o == halfword_right_arith);
	endfunction

	function automatic logic is_rot(input mcsr_op_t o);
		is_rot = (o == rotate_left) || (o == rotate_right);
	endfunction

	// Least time, rounded up to whole clock periods
	function automatic logic [TW-1:0] ns_to_cycles(input logic [15:0] ns);
		logic [15:0] c;
		c = (ns + 16'(`MCSR_CLK_NS - 1)) / 16'(`MCSR_CLK_NS);
		ns_to_cycles = (c == 16'h0) ? TW'(1) : c[TW-1:0];
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [31:0] opa_reg;
	logic [31:0] opb_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] result_reg;
	logic [15:0] mlc_reg;
	logic c_reg;
	logic v_reg;
	logic g_reg;
	logic l_reg;
	logic [31:0] prdata_reg;
	mcsr_state_t state_reg;
	mcsr_state_t state_next;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire [7:0] a8 = paddr[7:0];
	wire hit_opa = (a8 == `MCSR_OFF_OPA);
	wire hit_opb = (a8 == `MCSR_OFF_OPB);
	wire hit_ctrl = (a8 == `MCSR_OFF_CTRL);
	wire hit_res = (a8 == `MCSR_OFF_RESULT);
	wire hit_st = (a8 == `MCSR_OFF_STATUS);
	wire hit_mlc = (a8 == `MCSR_OFF_MLC);
	wire hi_zero = (AW <= 8) ? 1'b1 : (paddr >> 8) == '0;
	wire mapped = hi_zero &
		(hit_opa | hit_opb | hit_ctrl | hit_res | hit_st | hit_mlc);
	wire ro_hit = hit_res | hit_st;
	// Writes to live registers are refused while an operation runs,
	// so the barrel sees stable inputs without a snapshot copy
	wire locked = (state_reg != st_idle);
	wire access = psel & penable;
	wire bad = ~mapped | (pwrite & (ro_hit | locked));
	wire wr_ok = access & pwrite & ~bad & ce;

	// Zero wait states; clock enable low stalls the bus too
	assign pready = ce;
	assign pslverr = access & bad;
	assign prdata = prdata_reg;
	assign busy = locked;

	// ****************************************************************
	// Control word fields
	// ****************************************************************
	wire mcsr_op_t op_w =
		mcsr_op_t'(ctrl_reg[`MCSR_CTRL_OP_HI:`MCSR_CTRL_OP_LO]);
	wire xfer_w = ctrl_reg[`MCSR_CTRL_XFER];
	wire cond_w = ctrl_reg[`MCSR_CTRL_COND];
	wire imm_w = ctrl_reg[`MCSR_CTRL_IMM];
	wire [5:0] page_w =
		ctrl_reg[`MCSR_CTRL_PAGE_HI:`MCSR_CTRL_PAGE_LO];
	wire [11:0] data_w =
		ctrl_reg[`MCSR_CTRL_DATA_HI:`MCSR_CTRL_DATA_LO];
	wire half_w = is_half(op_w);
	wire rot_w = is_rot(op_w);

	// Immediate forms take the operand from the control word
	wire [31:0] opb_eff = imm_w ? {20'h0, data_w} : opb_reg;
	wire [4:0] cnt_w = opb_eff[4:0];

	// ****************************************************************
	// Datapath
	// ****************************************************************
	logic [31:0] res_w;
	logic carry_w;

	mcsr_barrel u_barrel (
		.op(op_w),
		.operand(opa_reg),
		.cnt(cnt_w),
		.result(res_w),
		.carry(carry_w)
	);

	// Flag field: halfword forms look at bits 15:0 only
	wire fld_sign = half_w ? res_w[15] : res_w[31];
	wire fld_zero = half_w ? (res_w[15:0] == 16'h0) : (res_w == 32'h0);
	wire g_w = ~fld_zero & ~fld_sign;
	wire l_w = fld_sign;

	// Transfer forms exist only for the full-word operations
	wire xfer_form = xfer_w & ~half_w;
	wire skip_w = xfer_form & ~rot_w & cond_w & carry_w;

	// ****************************************************************
	// Micro-location counter update
	// ****************************************************************
	wire [15:0] mlc_load = {mlc_reg[15:6], page_w};
	wire [11:0] mlc_low_inc = mlc_reg[11:0] + 12'h1;
	wire [15:0] mlc_inc = {mlc_reg[15:12], mlc_low_inc};
	// Rotates load the page with no carry test
	wire [15:0] mlc_after = rot_w ? mlc_load :
		(skip_w ? mlc_inc : mlc_load);

	// ****************************************************************
	// Timing
	// ****************************************************************
	// Positions actually moved: four count bits for halfwords
	wire [4:0] n_w = half_w ? {1'b0, cnt_w[3:0]} : cnt_w;
	wire [15:0] base_ns = skip_w ? 16'(`MCSR_NOXFER_NS) :
		16'(`MCSR_BASE_NS);
	wire [15:0] step_ns = 16'(`MCSR_STEP_NS) * {11'h0, n_w};
	wire [15:0] total_ns = base_ns + step_ns;
	wire [TW-1:0] cycles_w = ns_to_cycles(total_ns);

	logic t_busy;
	logic t_done;
	wire t_start = (state_reg == st_load);

	mcsr_timer #(
		.W(TW)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(t_start),
		.cycles(cycles_w),
		.busy(t_busy),
		.done(t_done)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Control write starts; timer paces; one commit cycle stores
	always_comb begin
		state_next = state_reg;
		case (state_reg)
		st_idle: begin
			if (wr_ok & hit_ctrl) begin
				state_next = st_load;
			end
		end
		st_load: begin
			state_next = st_run;
		end
		st_run: begin
			if (t_done | ~t_busy) begin
				state_next = st_commit;
			end
		end
		st_commit: begin
			state_next = st_idle;
		end
		default: begin
			state_next = st_idle;
		end
		endcase
	end

	wire commit = (state_reg == st_commit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= st_idle;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	// Operands and control word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_reg <= `MCSR_RST_WORD;
			opb_reg <= `MCSR_RST_WORD;
			ctrl_reg <= `MCSR_RST_WORD;
		end else if (wr_ok) begin
			if (hit_opa) begin
				opa_reg <= pwdata;
			end
			if (hit_opb) begin
				opb_reg <= pwdata;
			end
			if (hit_ctrl) begin
				ctrl_reg <= pwdata;
			end
		end
	end

	// Result and flags land together at commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= `MCSR_RST_WORD;
			c_reg <= 1'b0;
			v_reg <= 1'b0;
			g_reg <= 1'b0;
			l_reg <= 1'b0;
		end else if (ce & commit) begin
			result_reg <= res_w;
			c_reg <= carry_w;
			v_reg <= 1'b0;
			g_reg <= g_w;
			l_reg <= l_w;
		end
	end

	// Counter: software may set it while idle, transfers steer it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mlc_reg <= `MCSR_RST_MLC;
		end else if (ce & commit & xfer_form) begin
			mlc_reg <= mlc_after;
		end else if (wr_ok & hit_mlc) begin
			mlc_reg <= pwdata[15:0];
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	wire [31:0] status_w = {27'h0, l_reg, g_reg, v_reg, c_reg, busy};
	wire [31:0] rd_mux =
		~mapped ? 32'h0 :
		hit_opa ? opa_reg :
		hit_opb ? opb_reg :
		hit_ctrl ? ctrl_reg :
		hit_res ? result_reg :
		hit_st ? status_w :
		{16'h0, mlc_reg};

	// Read data is caught in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= `MCSR_RST_WORD;
		end else if (ce & psel & ~penable & ~pwrite) begin
			prdata_reg <= rd_mux;
		end
	end

endmodule
`default_nettype wire

//--- bench/mcsr_props.sv
/* Assertions on the APB ports of the shift and rotate unit.
   Assumes an 8-bit address and a bind onto every mcsr_unit. */
`timescale 1ns/1ps
`default_nettype none
module mcsr_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy
);
	// ********
	// Decodes
	// ********
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A start needs an idle unit, so go excludes locked writes
	wire acc = psel && penable && ce;
	wire go = acc && pwrite && paddr == 8'h08 && !busy;
	wire rd_st = acc && !pwrite && paddr == 8'h10;
	wire ro = paddr == 8'h0c || paddr == 8'h10;
	wire bad = paddr > 8'h14;
	wire good = acc && !bad && paddr[1:0] == 2'h0 && !(pwrite && (ro || busy));
	// ********
	// Properties
	// ********
	AST_GO_HOLD: assert property (go |=> busy [*4])
		else $error("busy dropped too soon");
	AST_GO_END: assert property (go |-> ##[6:27] !busy)
		else $error("busy held too long");
	AST_LOCKED: assert property (
		acc && pwrite && busy |-> pslverr)
		else $error("write accepted while busy");
	AST_RO: assert property (acc && pwrite && ro |-> pslverr)
		else $error("write to read-only register accepted");
	AST_MAPPED: assert property (good |-> !pslverr)
		else $error("legal access refused");
	// Writes do not refresh read data, so only reads must show zero
	AST_UNMAP: assert property (acc && bad |-> pslverr &&
		(pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	AST_ST_BUSY: assert property (
		rd_st |-> prdata[0] == $past(busy))
		else $error("status busy bit wrong");
	AST_FLAGS: assert property (
		rd_st |-> !prdata[2] && !(&prdata[4:3]))
		else $error("overflow set or greater with less");
	AST_READY: assert property (pready == ce)
		else $error("pready differs from ce");
endmodule
bind mcsr_unit mcsr_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

//--- bench/testbench.sv
/* Self-checking bench for the shift and rotate unit over APB.
   Assumes the unit answers when ce is high; ce drops in one scenario. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, ce, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, busy, err;
	int n_fail, checks;

	mcsr_unit dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy)
	);

	// ********
	// Helpers
	// ********
	task automatic conclude();
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One transfer; starts a cycle late so strobes never toggle twice
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Runs one operation and judges result, flags, counter and time
	task automatic run_op(input logic [2:0] op, input logic [31:0] a, b,
			input logic x, cnd, im, input logic [11:0] dat);
		logic [31:0] be, r, v, st, m, u;
		logic cy, hw, inc;
		int k, cyc, kk;
		be = im ? {20'h0, dat} : b;
		hw = op == 3'h1 || op == 3'h3 || op == 3'h5;
		k = hw ? be[3:0] : be[4:0];
		r = a;
		cy = 1'b0;
		if (k != 0) begin
			case (op)
			3'h0: r = a >> k;
			3'h1: r = {a[31:16], a[15:0] >> k};
			3'h2: r = {a[31], a[30:0] << k};
			3'h3: r = {a[31:15], a[14:0] << k};
			3'h4: r = $signed(a) >>> k;
			3'h5: r = {a[31:15], 15'($signed(a[15:0]) >>> k)};
			3'h6: r = a << k | a >> (32 - k);
			default: r = a >> k | a << (32 - k);
			endcase
			cy = op == 3'h2 ? a[31-k] : op == 3'h3 ? a[15-k] : op < 3'h6 && a[k-1];
		end
		v = hw ? {{16{r[15]}}, r[15:0]} : r;
		st = {27'h0, v[31], !v[31] && v != 0, 1'b0, cy, 1'b0};
		inc = x && !hw && op < 3'h6 && cnd && cy;
		m = {16'h0, !x || hw ? 16'h5fff : inc ? 16'h5000 : 16'h5fea};
		// Write edge to the edge back at idle spans K + 2 edges; the
		// loop below takes one more sample before it sees idle
		kk = ((inc ? 500 : 360) + 60 * k + 99) / 100 + 3;
		apb(1'b1, 8'h14, 32'h5fff);
		apb(1'b1, 8'h00, a);
		apb(1'b1, 8'h04, b);
		apb(1'b1, 8'h08, {dat, 6'h0, 6'h2a, 1'b0, im, cnd, x, 1'b0, op});
		// Busy is looked at mid-cycle, where it has settled
		cyc = 0;
		do begin
			@(negedge pclk);
			cyc++;
		end while (busy === 1'b1 && cyc < 99);
		chk(32'(cyc), 32'(kk));
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, r);
		// Turning a rotate back by the same count must give the operand
		u = op[0] ? rd << k | rd >> (32 - k) : rd >> k | rd << (32 - k);
		if (op >= 3'h6)
			chk(u, a);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, st);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, m);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
	endtask

	// Counts 0, 1, 7 and the top; upper count bits set to be ignored
	task automatic t_ops();
		logic [31:0] pat [3];
		logic [4:0] cn [4];
		pat = '{32'h8001_c003, 32'h4000_7ffe, 32'hffff_0001};
		cn = '{5'h0, 5'h1, 5'h7, 5'h1f};
		for (int o = 0; o < 8; o++)
			foreach (pat[p])
				foreach (cn[c])
					run_op(3'(o), pat[p], {27'h7ff_ffff, cn[c]}, 1'b0, 1'b0, 1'b0, 12'h0);
	endtask

	// Carry out is one for the shifts, so cond decides between increment and load for the full-word ones; the last run has carry zero
	task automatic t_xfer();
		for (int o = 0; o < 8; o++)
			for (int c = 0; c < 2; c++)
				run_op(3'(o), 32'hffff_ffff, 32'h1, 1'b1, c[0], 1'b0, 12'h0);
		run_op(3'h0, 32'hffff_fffe, 32'h1, 1'b1, 1'b1, 1'b0, 12'h0);
	endtask

	// Operand register holds 3 but the data field asks for 5
	task automatic t_imm();
		for (int o = 0; o < 8; o++)
			run_op(3'(o), 32'h9abc_def1, 32'h3, 1'b0, 1'b0, 1'b1, 12'hfe5);
	endtask

	task automatic t_refuse();
		apb(1'b1, 8'h00, 32'h9234_5678);
		apb(1'b1, 8'h04, 32'h1f);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd & 32'h1, 32'h1);
		while (busy === 1'b1)
			@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h9234_5678);
		apb(1'b1, 8'h0c, 32'h5);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 8'h40, 32'h5);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Clock enable low stalls sequencer, timer and bus alike; a zero
	// count takes four cycles of time, so idle comes at the 7th sample
	task automatic t_freeze();
		int cyc;
		apb(1'b1, 8'h00, 32'h8000_0001);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		ce <= 1'b0;
		repeat (10) @(negedge pclk);
		chk({30'h0, pready, busy}, 32'h1);
		@(posedge pclk);
		ce <= 1'b1;
		cyc = 0;
		do begin
			@(negedge pclk);
			cyc++;
		end while (busy === 1'b1 && cyc < 99);
		chk(32'(cyc), 32'h7);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h8000_0001);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h10);
	endtask

	// ********
	// Run
	// ********
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// The run needs some 4000 cycles; 20000 means a hang
	initial begin
		#2000000;
		n_fail++;
		conclude();
	end

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ops();
		t_xfer();
		t_imm();
		t_refuse();
		t_freeze();
		conclude();
	end
endmodule
`default_nettype wire
